//--- hw/bia_top.sv
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
`include "bia_defines.svh"

module bia_top
	import bia_pkg::*;
#(
	parameter int NLINE = 8
) (
	// clock and reset
	input  wire logic             SYS_CLK,
	input  wire logic             NRST,
	// wishbone slave
	input  wire logic             WB_CYC_I,
	input  wire logic             WB_STB_I,
	input  wire logic             WB_WE_I,
	input  wire logic [11:0]      WB_ADR_I,
	input  wire logic [3:0]       WB_SEL_I,
	input  wire logic [31:0]      WB_DAT_I,
	output logic      [31:0]      WB_DAT_O,
	output logic                  WB_ACK_O,
	// event sources, one-cycle pulses
	input  wire logic             FRAME_TIMER_EXPIRED,
	input  wire logic             FRAME_TRIGGER,
	input  wire logic [3:0]       INPUT_CONV_DONE,
	input  wire logic [1:0]       OUTPUT_CONV_UPDATED,
	input  wire logic             INPUT_SEQ_DONE,
	input  wire logic [2:0]       INPUT_BUF_END_REASON,
	input  wire logic             OUTPUT_SEQ_DONE,
	input  wire logic             OUTPUT_BUF_DRAINED,
	input  wire logic [31:0]      ERROR_EVENTS,
	// filtered digital lines
	input  wire logic [NLINE-1:0] LINE_IN,
	// host interrupt
	output logic                  HOST_IRQ
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [31:0]      en_main;
		logic [31:0]      en_err;
		logic [NLINE-1:0] en_rise;
		logic [NLINE-1:0] en_fall;
		logic [1:0]       gcfg;
		logic             ack;
		logic [31:0]      dat;
		logic             irq;
	} bia_top_state_t;

	bia_top_state_t s_r;
	bia_top_state_t s_nxt;

	logic [31:0]      st_main;
	logic [31:0]      st_err;
	logic [NLINE-1:0] st_line;
	logic [31:0]      main_evt;
	logic [31:0]      clr_main;
	logic [31:0]      clr_err;
	logic [NLINE-1:0] clr_line;
	logic [NLINE-1:0] line_evt;
	logic [31:0]      main_full;
	logic [31:0]      rd_val;
	logic             req;
	logic             do_wr;
	logic             do_rd;
	bia_ack_mode_t    ack_mode;
	logic [31:0]      sel_mask;

	function automatic logic [31:0] byte_mask(input logic [3:0] sel);
		return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction : byte_mask

	assign sel_mask = byte_mask(WB_SEL_I);

	// ****************************************
	// event collection
	// ****************************************
	always_comb begin
		main_evt = '0;
		main_evt[`BIA_BIT_FTIM] = FRAME_TIMER_EXPIRED;
		main_evt[`BIA_BIT_FTRIG] = FRAME_TRIGGER;
		main_evt[`BIA_LSB_ADC +: 4] = INPUT_CONV_DONE;
		main_evt[`BIA_LSB_DAC +: 2] = OUTPUT_CONV_UPDATED;
		main_evt[`BIA_BIT_ISEQ] = INPUT_SEQ_DONE;
		main_evt[`BIA_LSB_IBUF +: 3] = INPUT_BUF_END_REASON;
		main_evt[`BIA_BIT_OSEQ] = OUTPUT_SEQ_DONE;
		main_evt[`BIA_BIT_OBUF] = OUTPUT_BUF_DRAINED;
	end

	// enable bit 8 widened over the three end-reason bits
	logic [31:0] en_main_eff;
	always_comb begin
		en_main_eff = s_r.en_main;
		en_main_eff[`BIA_LSB_IBUF +: 3] =
			{3{s_r.en_main[`BIA_LSB_IBUF]}};
	end

	// ****************************************
	// wishbone decode
	// ****************************************
	assign ack_mode = bia_ack_mode_t'(s_r.gcfg[`BIA_BIT_ACK_MODE]);
	assign req = WB_CYC_I && WB_STB_I && !s_r.ack;
	assign do_wr = req && WB_WE_I;
	assign do_rd = req && !WB_WE_I;

	// clears: write-one in mode 0, byte-selected read in mode 1
	always_comb begin
		clr_main = '0;
		clr_err = '0;
		clr_line = '0;
		if (ack_mode == BIA_ACK_WRITE && do_wr) begin
			case (WB_ADR_I)
				`BIA_OFS_ST_MAIN: clr_main =
					WB_DAT_I & byte_mask(WB_SEL_I);
				`BIA_OFS_ST_ERR: clr_err =
					WB_DAT_I & byte_mask(WB_SEL_I);
				`BIA_OFS_ST_LINE: clr_line =
					WB_DAT_I[NLINE-1:0] & sel_mask[NLINE-1:0];
				default: ;
			endcase
		end else if (ack_mode == BIA_ACK_READ && do_rd) begin
			case (WB_ADR_I)
				`BIA_OFS_ST_MAIN: clr_main = byte_mask(WB_SEL_I);
				`BIA_OFS_ST_ERR: clr_err = byte_mask(WB_SEL_I);
				`BIA_OFS_ST_LINE: clr_line =
					sel_mask[NLINE-1:0];
				default: ;
			endcase
		end
	end

	// ****************************************
	// sticky banks
	// ****************************************
	bia_sticky #(.W(32)) u_main (
		.clk       (SYS_CLK),
		.nrst      (NRST),
		.event_in  (main_evt),
		.enable_in (en_main_eff & `BIA_MASK_ST_MAIN),
		.clear_in  (clr_main),
		.status    (st_main)
	);

	bia_sticky #(.W(32)) u_err (
		.clk       (SYS_CLK),
		.nrst      (NRST),
		.event_in  (ERROR_EVENTS),
		.enable_in (s_r.en_err & `BIA_MASK_ERR),
		.clear_in  (clr_err),
		.status    (st_err)
	);

	bia_line_edge #(.N(NLINE)) u_edge (
		.clk      (SYS_CLK),
		.nrst     (NRST),
		.line_in  (LINE_IN),
		.rise_en  (s_r.en_rise),
		.fall_en  (s_r.en_fall),
		.edge_evt (line_evt)
	);

	bia_sticky #(.W(NLINE)) u_line (
		.clk       (SYS_CLK),
		.nrst      (NRST),
		.event_in  (line_evt),
		.enable_in ({NLINE{1'b1}}),
		.clear_in  (clr_line),
		.status    (st_line)
	);

	// summaries are live ORs, never cleared directly
	always_comb begin
		main_full = st_main & `BIA_MASK_ST_MAIN;
		main_full[`BIA_BIT_LINE_SUM] = |st_line;
		main_full[`BIA_BIT_ERR_SUM] = |st_err;
	end

	// ****************************************
	// read mux
	// ****************************************
	always_comb begin
		case (WB_ADR_I)
			`BIA_OFS_EN_MAIN: rd_val = s_r.en_main;
			`BIA_OFS_EN_ERR: rd_val = s_r.en_err;
			`BIA_OFS_EN_RISE: rd_val = 32'(s_r.en_rise);
			`BIA_OFS_EN_FALL: rd_val = 32'(s_r.en_fall);
			`BIA_OFS_ST_MAIN: rd_val = main_full;
			`BIA_OFS_ST_ERR: rd_val = st_err;
			`BIA_OFS_ST_LINE: rd_val = 32'(st_line);
			`BIA_OFS_GCFG: rd_val = 32'(s_r.gcfg);
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// ****************************************
	// register update
	// ****************************************
	always_comb begin
		logic [31:0] m;
		m = byte_mask(WB_SEL_I);
		s_nxt = s_r;
		s_nxt.ack = req;
		s_nxt.dat = do_rd ? rd_val : s_r.dat;
		if (do_wr) begin
			case (WB_ADR_I)
				`BIA_OFS_EN_MAIN: s_nxt.en_main = ((s_r.en_main & ~m) |
					(WB_DAT_I & m)) & `BIA_MASK_EN_MAIN;
				`BIA_OFS_EN_ERR: s_nxt.en_err = ((s_r.en_err & ~m) |
					(WB_DAT_I & m)) & `BIA_MASK_ERR;
				`BIA_OFS_EN_RISE: if (WB_SEL_I[0]) begin
					s_nxt.en_rise = WB_DAT_I[NLINE-1:0];
				end
				`BIA_OFS_EN_FALL: if (WB_SEL_I[0]) begin
					s_nxt.en_fall = WB_DAT_I[NLINE-1:0];
				end
				`BIA_OFS_GCFG: if (WB_SEL_I[0]) begin
					s_nxt.gcfg = WB_DAT_I[1:0];
				end
				default: ;
			endcase
		end
		// follows the registered status, two cycles behind an event
		s_nxt.irq = |main_full;
	end

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign WB_ACK_O = s_r.ack;
	assign WB_DAT_O = s_r.dat;
	assign HOST_IRQ = s_r.irq;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!NRST);

	AST_DISABLED_DROP: assert property (
		(FRAME_TRIGGER && !s_r.en_main[`BIA_BIT_FTRIG] &&
		 !st_main[`BIA_BIT_FTRIG]) |=> !st_main[`BIA_BIT_FTRIG])
		else $error("frame trigger latched while disabled");

	AST_ENABLED_SET: assert property (
		(FRAME_TIMER_EXPIRED && s_r.en_main[`BIA_BIT_FTIM])
		|=> st_main[`BIA_BIT_FTIM])
		else $error("frame timer event not latched");

	AST_STICKY_HOLD: assert property (
		(st_main[`BIA_BIT_ISEQ] && !(req &&
		 WB_ADR_I == `BIA_OFS_ST_MAIN)) |=> st_main[`BIA_BIT_ISEQ])
		else $error("status bit dropped without acknowledge");

	AST_WRITE_CLEAR: assert property (
		(do_wr && !s_r.gcfg[1] && WB_ADR_I == `BIA_OFS_ST_MAIN &&
		 WB_SEL_I[3] && WB_DAT_I[`BIA_BIT_FTRIG] && !FRAME_TRIGGER)
		|=> !st_main[`BIA_BIT_FTRIG])
		else $error("write-one did not clear");

	AST_READ_CLEAR_BYTE: assert property (
		(do_rd && s_r.gcfg[1] && WB_ADR_I == `BIA_OFS_ST_MAIN &&
		 !WB_SEL_I[1] && st_main[`BIA_BIT_ISEQ])
		|=> st_main[`BIA_BIT_ISEQ])
		else $error("unselected byte cleared on read");

	AST_READ_NO_CLEAR_MODE0: assert property (
		(do_rd && !s_r.gcfg[1] && st_main[`BIA_BIT_OSEQ])
		|=> st_main[`BIA_BIT_OSEQ])
		else $error("read cleared status in write mode");

	AST_IRQ_FOLLOWS: assert property (
		##1 (HOST_IRQ == $past(|main_full)))
		else $error("interrupt does not follow status");

	AST_LINE_SUMMARY: assert property (
		(do_rd && WB_ADR_I == `BIA_OFS_ST_MAIN)
		|=> (WB_DAT_O[`BIA_BIT_LINE_SUM] == $past(|st_line)))
		else $error("line summary mismatch");

	AST_ERR_SUMMARY: assert property (
		(do_rd && WB_ADR_I == `BIA_OFS_ST_MAIN)
		|=> (WB_DAT_O[`BIA_BIT_ERR_SUM] == $past(|st_err)))
		else $error("error summary mismatch");

	AST_RESERVED_ZERO: assert property (
		(do_rd && WB_ADR_I == `BIA_OFS_ST_MAIN)
		|=> ((WB_DAT_O & 32'h00fc_e8ee) == 32'h0000_0000))
		else $error("reserved status bit reads one");

	AST_CONV_SET: assert property (
		(INPUT_CONV_DONE[0] && s_r.en_main[`BIA_LSB_ADC])
		|=> st_main[`BIA_LSB_ADC])
		else $error("converter done not latched");

	AST_ERR_SET: assert property (
		(ERROR_EVENTS[0] && s_r.en_err[0]) |=> st_err[0])
		else $error("error event not latched");

	AST_LINE_RISE: assert property (
		($past(NRST) && LINE_IN[0] && !$past(LINE_IN[0]) &&
		 s_r.en_rise[0]) |=> st_line[0])
		else $error("rising line edge not latched");

	AST_LINE_FALL: assert property (
		($past(NRST) && !LINE_IN[0] && $past(LINE_IN[0]) &&
		 s_r.en_fall[0]) |=> st_line[0])
		else $error("falling line edge not latched");

	AST_BUF_GATE: assert property (
		(INPUT_BUF_END_REASON[2] && s_r.en_main[`BIA_LSB_IBUF])
		|=> st_main[`BIA_LSB_IBUF+2])
		else $error("end reason not latched");

	AST_ACK_PULSE: assert property (
		WB_ACK_O |=> !WB_ACK_O)
		else $error("ack held longer than one cycle");

	COV_IRQ: cover property (!HOST_IRQ ##1 HOST_IRQ);
	COV_RD_CLEAR: cover property (do_rd && s_r.gcfg[1] && |st_main);
	COV_LINE: cover property (|line_evt);
	COV_ERR: cover property (|st_err ##1 !(|st_err));
endmodule : bia_top

//--- hw/bia_defines.svh
`ifndef BIA_DEFINES_SVH
`define BIA_DEFINES_SVH

// register byte offsets
`define BIA_OFS_EN_MAIN    12'h36c
`define BIA_OFS_EN_ERR     12'h370
`define BIA_OFS_EN_RISE    12'h374
`define BIA_OFS_EN_FALL    12'h378
`define BIA_OFS_ST_MAIN    12'h384
`define BIA_OFS_ST_ERR     12'h388
`define BIA_OFS_ST_LINE    12'h38c
`define BIA_OFS_GCFG       12'h398

// writable/implemented bit masks
`define BIA_MASK_EN_MAIN   32'h3f03_1111
`define BIA_MASK_ERR       32'h0f0f_0003
`define BIA_MASK_LINE      32'h0000_00ff
`define BIA_MASK_ST_MAIN   32'h3f03_1711
`define BIA_MASK_GCFG      32'h0000_0003

// status and config field positions
`define BIA_BIT_LINE_SUM   31
`define BIA_BIT_ERR_SUM    30
`define BIA_BIT_FTIM       29
`define BIA_BIT_FTRIG      28
`define BIA_LSB_ADC        24
`define BIA_LSB_DAC        16
`define BIA_BIT_ISEQ       12
`define BIA_LSB_IBUF       8
`define BIA_BIT_OSEQ       4
`define BIA_BIT_OBUF       0
`define BIA_BIT_ACK_MODE   1

`define BIA_RESET_VAL      32'h0000_0000

`endif

//--- hw/bia_pkg.sv
package bia_pkg;
	typedef enum logic {
		BIA_ACK_WRITE,
		BIA_ACK_READ
	} bia_ack_mode_t;

	typedef enum {
		BIA_BUS_IDLE,
		BIA_BUS_ACK
	} bia_bus_state_t;
endpackage : bia_pkg

//--- hw/bia_sticky.sv
`timescale 1ns/1ps
`include "bia_defines.svh"

// bank of sticky event bits with enable gating and per-bit clearing
module bia_sticky
	import bia_pkg::*;
#(
	parameter int W = 32
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         nrst,
	// event side
	input  wire logic [W-1:0] event_in,
	input  wire logic [W-1:0] enable_in,
	// clear side
	input  wire logic [W-1:0] clear_in,
	// state
	output logic      [W-1:0] status
);
	typedef struct packed {
		logic [W-1:0] st;
	} bia_stk_state_t;

	bia_stk_state_t s_r;
	bia_stk_state_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		// set wins over clear
		s_nxt.st = (s_r.st & ~clear_in) | (event_in & enable_in);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign status = s_r.st;
endmodule : bia_sticky

//--- hw/bia_line_edge.sv
`timescale 1ns/1ps
`include "bia_defines.svh"

// edge detector on filtered digital lines, gated per edge direction
module bia_line_edge
	import bia_pkg::*;
#(
	parameter int N = 8
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         nrst,
	// lines and enables
	input  wire logic [N-1:0] line_in,
	input  wire logic [N-1:0] rise_en,
	input  wire logic [N-1:0] fall_en,
	// gated edge pulses
	output logic      [N-1:0] edge_evt
);
	typedef struct packed {
		logic [N-1:0] prev;
		logic         primed;
	} bia_edge_state_t;

	bia_edge_state_t s_r;
	bia_edge_state_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.prev = line_in;
		s_nxt.primed = 1'b1;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// no edge reported on the first cycle after reset
	assign edge_evt = s_r.primed ?
		((line_in & ~s_r.prev & rise_en) |
		 (~line_in & s_r.prev & fall_en)) : '0;
endmodule : bia_line_edge

//--- testbench/bia_src_model.sv
`timescale 1ns/1ps
// ************************************
// event sources feeding the aggregator
// ************************************
// a request held for one cycle, laid out like the status registers,
// comes out one cycle later as one-cycle event pulses
module bia_src_model
	import bia_pkg::*;
(
	// clock
	input  wire logic        clk,
	// requests
	input  wire logic [31:0] fire,
	input  wire logic [31:0] err_fire,
	// event pulses
	output logic             ftim,
	output logic             ftrig,
	output logic      [3:0]  in_conv,
	output logic      [1:0]  out_conv,
	output logic             in_seq,
	output logic      [2:0]  in_buf,
	output logic             out_seq,
	output logic             out_buf,
	output logic      [31:0] err
);
	logic [31:0] main_r = 32'h0000_0000;
	logic [31:0] err_r  = 32'h0000_0000;

	always @(posedge clk) begin
		main_r <= fire;
		err_r  <= err_fire;
	end

	assign ftim     = main_r[29];
	assign ftrig    = main_r[28];
	assign in_conv  = main_r[27:24];
	assign out_conv = main_r[17:16];
	assign in_seq   = main_r[12];
	assign in_buf   = main_r[10:8];
	assign out_seq  = main_r[4];
	assign out_buf  = main_r[0];
	assign err      = err_r;
endmodule : bia_src_model

//--- testbench/bia_top_test.sv
`timescale 1ns/1ps
module bia_top_test;
	import bia_pkg::*;
	logic        sys_clk  = 1'b0;
	logic        nrst     = 1'b0;
	logic        cyc      = 1'b0;
	logic        stb      = 1'b0;
	logic        we       = 1'b0;
	logic [11:0] adr      = 12'h000;
	logic [3:0]  sel      = 4'h0;
	logic [31:0] dat      = 32'h0000_0000;
	logic [31:0] fire     = 32'h0000_0000;
	logic [31:0] err_fire = 32'h0000_0000;
	logic [7:0]  lines    = 8'h00;
	logic [31:0] rdat;
	logic [31:0] dat_o;
	logic [31:0] ev_err;
	logic        ack;
	logic        irq;
	logic        ftim;
	logic        ftrig;
	logic        in_seq;
	logic        out_seq;
	logic        out_buf;
	logic [3:0]  in_conv;
	logic [1:0]  out_conv;
	logic [2:0]  in_buf;
	int          error_cnt   = 0;
	int          comparisons = 0;
	logic [11:0] ofs [6] = '{12'h36c, 12'h370, 12'h374, 12'h378, 12'h398,
		12'h3fc};
	logic [31:0] msk [6] = '{32'h3f03_1111, 32'h0f0f_0003, 32'h0000_00ff,
		32'h0000_00ff, 32'h0000_0003, 32'h0000_0000};

	bia_src_model src_u (.clk(sys_clk), .fire(fire), .err_fire(err_fire),
		.ftim(ftim), .ftrig(ftrig), .in_conv(in_conv), .out_conv(out_conv),
		.in_seq(in_seq), .in_buf(in_buf), .out_seq(out_seq),
		.out_buf(out_buf), .err(ev_err));

	bia_top #(.NLINE(8)) dut_u (.SYS_CLK(sys_clk), .NRST(nrst),
		.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
		.FRAME_TIMER_EXPIRED(ftim), .FRAME_TRIGGER(ftrig),
		.INPUT_CONV_DONE(in_conv), .OUTPUT_CONV_UPDATED(out_conv),
		.INPUT_SEQ_DONE(in_seq), .INPUT_BUF_END_REASON(in_buf),
		.OUTPUT_SEQ_DONE(out_seq), .OUTPUT_BUF_DRAINED(out_buf),
		.ERROR_EVENTS(ev_err), .LINE_IN(lines), .HOST_IRQ(irq));

	always #10 sys_clk = ~sys_clk;

	// ************************************
	// bus cycles and comparisons
	// ************************************
	task automatic final_report;
		$display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h, want %h", $time, got, exp);
		end
	endtask : chk

	// entered and left just after a rising edge
	task automatic wb(input logic w, input logic [11:0] a,
		input logic [3:0] s, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		sel <= s;
		dat <= d;
		@(posedge sys_clk);
		while (ack !== 1'b1) begin
			n++;
			if (n > 20) begin
				error_cnt++;
				$display("wrong value at %0t: no bus answer", $time);
				final_report();
			end
			@(posedge sys_clk);
		end
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge sys_clk);
	endtask : wb

	task automatic rd(input logic [11:0] a, input logic [3:0] s,
		input logic [31:0] e);
		wb(1'b0, a, s, 32'h0000_0000);
		chk(rdat, e);
	endtask : rd

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		wb(1'b1, a, 4'hf, d);
	endtask : wr

	task automatic pulse(input logic [31:0] m, input logic [31:0] e);
		fire     <= m;
		err_fire <= e;
		@(posedge sys_clk);
		fire     <= 32'h0000_0000;
		err_fire <= 32'h0000_0000;
		repeat (3) @(posedge sys_clk);
	endtask : pulse

	task automatic setl(input logic [7:0] v);
		lines <= v;
		repeat (3) @(posedge sys_clk);
	endtask : setl

	task automatic endt(input string s);
		$display("test %s done", s);
	endtask : endt

	// ************************************
	// test sequence
	// ************************************
	initial begin
		repeat (8) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		rd(12'h384, 4'hf, 32'h0);
		rd(12'h388, 4'hf, 32'h0);
		rd(12'h38c, 4'hf, 32'h0);
		chk({31'h0, irq}, 32'h0);
		for (int i = 0; i < 6; i++) begin
			rd(ofs[i], 4'hf, 32'h0);
			wr(ofs[i], 32'hffff_ffff);
			rd(ofs[i], 4'hf, msk[i]);
			wr(ofs[i], 32'h0);
		end
		endt("registers");
		pulse(32'h3f03_1711, 32'hffff_ffff);
		setl(8'hff);
		setl(8'h00);
		rd(12'h384, 4'hf, 32'h0);
		rd(12'h388, 4'hf, 32'h0);
		rd(12'h38c, 4'hf, 32'h0);
		wr(12'h36c, 32'h0000_0100);
		pulse(32'h3f03_1711, 32'h0);
		rd(12'h384, 4'hf, 32'h0000_0700);
		wr(12'h384, 32'hffff_ffff);
		endt("disabled");
		wr(12'h36c, 32'hffff_ffff);
		pulse(32'h3f03_1711, 32'h0);
		rd(12'h384, 4'hf, 32'h3f03_1711);
		chk({31'h0, irq}, 32'h1);
		wr(12'h36c, 32'h0);
		rd(12'h384, 4'hf, 32'h3f03_1711);
		wr(12'h384, 32'h0000_ffff);
		rd(12'h384, 4'hf, 32'h3f03_0000);
		wr(12'h384, 32'hffff_ffff);
		rd(12'h384, 4'hf, 32'h0);
		chk({31'h0, irq}, 32'h0);
		endt("main events");
		wr(12'h370, 32'hffff_ffff);
		pulse(32'h0, 32'hffff_ffff);
		rd(12'h388, 4'hf, 32'h0f0f_0003);
		rd(12'h384, 4'hf, 32'h4000_0000);
		chk({31'h0, irq}, 32'h1);
		wr(12'h388, 32'hffff_ffff);
		rd(12'h384, 4'hf, 32'h0);
		wr(12'h370, 32'h0);
		endt("errors");
		wr(12'h374, 32'h0000_0055);
		wr(12'h378, 32'h0000_000f);
		setl(8'hff);
		rd(12'h38c, 4'hf, 32'h0000_0055);
		setl(8'h00);
		rd(12'h38c, 4'hf, 32'h0000_005f);
		wr(12'h384, 32'hffff_ffff);
		rd(12'h384, 4'hf, 32'h8000_0000);
		wr(12'h38c, 32'h0000_00ff);
		rd(12'h384, 4'hf, 32'h0);
		endt("lines");
		wr(12'h398, 32'h0000_0002);
		wr(12'h36c, 32'hffff_ffff);
		pulse(32'h3f03_1711, 32'h0);
		wr(12'h384, 32'hffff_ffff);
		rd(12'h384, 4'h1, 32'h3f03_1711);
		rd(12'h384, 4'h8, 32'h3f03_1700);
		rd(12'h384, 4'hf, 32'h0003_1700);
		rd(12'h384, 4'hf, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(12'h370, 32'hffff_ffff);
		pulse(32'h0, 32'hffff_ffff);
		rd(12'h384, 4'hf, 32'h4000_0000);
		rd(12'h388, 4'h4, 32'h0f0f_0003);
		rd(12'h388, 4'hf, 32'h0f00_0003);
		rd(12'h388, 4'hf, 32'h0);
		setl(8'hff);
		rd(12'h38c, 4'h2, 32'h0000_0055);
		rd(12'h38c, 4'h1, 32'h0000_0055);
		rd(12'h38c, 4'hf, 32'h0);
		chk({31'h0, irq}, 32'h0);
		endt("clear on read");
		final_report();
	end
endmodule : bia_top_test
